// File: src/cmc_pkg.sv
package cmc_pkg;
    // register byte offsets
    localparam logic [7:0] CMC_MASTER_CONTROL_OFF = 8'h00;
    localparam logic [7:0] CMC_MASTER_STATUS_OFF = 8'h04;
    localparam logic [7:0] CMC_DIAGNOSTIC_CONFIG_OFF = 8'h08;
    localparam logic [7:0] CMC_IRQ_ENABLE_OFF = 8'h0C;
    localparam logic [7:0] CMC_CAPABILITY_OFF = 8'h10;
    // master_control_reg fields
    localparam int CMC_INIT_REQUEST_BIT = 0;
    localparam int CMC_SLEEP_REQUEST_BIT = 1;
    localparam int CMC_AUTO_WAKEUP_BIT = 2;
    // master_status_reg fields
    localparam int CMC_INIT_ACK_BIT = 0;
    localparam int CMC_SLEEP_ACK_BIT = 1;
    localparam int CMC_WAKEUP_FLAG_BIT = 2;
    localparam int CMC_PULLUP_BIT = 3;
    localparam int CMC_RX_LEVEL_BIT = 4;
    // diagnostic_config_reg fields
    localparam int CMC_SILENT_BIT = 0;
    localparam int CMC_LOOPBACK_BIT = 1;
    // irq_enable_reg fields
    localparam int CMC_WAKEUP_IRQ_EN_BIT = 0;
    // reset values
    localparam logic CMC_INIT_REQUEST_RST = 1'b0;
    localparam logic CMC_SLEEP_REQUEST_RST = 1'b1;
    localparam logic CMC_SLEEP_ACK_RST = 1'b1;
    localparam logic CMC_PULLUP_RST = 1'b1;
    // bus idle detection
    localparam int CMC_IDLE_BITS = 11;
    localparam logic [3:0] CMC_IDLE_LAST = 4'(CMC_IDLE_BITS - 1);
    // core capabilities
    localparam int CMC_TX_MAILBOXES = 3;
    localparam int CMC_RX_FIFOS = 2;
    localparam int CMC_RX_FIFO_DEPTH = 3;
    localparam int CMC_STD_ID_BITS = 11;
    localparam int CMC_EXT_ID_BITS = 29;

    typedef enum logic [1:0] {
        cmc_st_sleep,
        cmc_st_init,
        cmc_st_sync,
        cmc_st_normal
    } cmc_state_e;
endpackage

// File: src/cmc_mode_ctrl.sv
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Function
// - hardware reset puts the controller in sleep with receive pull-up on
// - init or sleep request is acknowledged on entry, pull-up then released
// - normal mode whenever both init and sleep acknowledges are clear; here init acknowledge already clears on entering sync, before normal
// - before normal mode wait for eleven consecutive recessive bits
// - clearing init request leaves init once hardware clears init acknowledge
// - in init mode bus transfers stop and transmit pin stays recessive
// - entering init leaves configuration registers untouched
// - in sleep the core clock stops; wake-up flag and receive level status bits still update
// - init request while asleep is not acknowledged
// - bus activity in sleep clears sleep request when auto wake-up set
// - bus activity in sleep raises wake-up interrupt when enabled
// - after sleep request clears, sync to bus before clearing sleep acknowledge
// - silent mode receives but sends only recessive, never starts transmission
// - silent mode feeds dominant bits back internally to the core
// - loop-back mode receives own frames through acceptance filtering
// - loop-back mode ignores acknowledge errors
// - loop-back feeds transmit to receive, pin ignored, transmit still visible
// - silent plus loop-back disconnects receive pin and holds transmit recessive
// - standard 11-bit and extended 29-bit identifiers handled in hardware
// - three transmit mailboxes and two receive fifos of three messages
module cmc_mode_ctrl
    import cmc_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic bus_receive_pin,
    output logic bus_transmit_pin,
    output logic receive_pullup_pin,
    input wire logic core_tx,
    input wire logic core_bit_tick,
    output logic core_rx,
    output logic core_clk_en,
    output logic core_enable,
    output logic core_tx_allow,
    output logic core_ack_err_ignore,
    output logic core_self_receive,
    output logic wakeup_irq
);

    cmc_state_e state_q;
    cmc_state_e state_d;
    logic init_request_q;
    logic sleep_request_q;
    logic sleep_request_d;
    logic auto_wakeup_select_q;
    logic silent_select_q;
    logic loopback_select_q;
    logic wakeup_irq_enable_q;
    logic init_acknowledge_q;
    logic init_acknowledge_d;
    logic sleep_acknowledge_q;
    logic sleep_acknowledge_d;
    logic wakeup_flag_q;
    logic wakeup_flag_d;
    logic pullup_q;
    logic pullup_d;
    logic [3:0] idle_cnt_q;
    logic [3:0] idle_cnt_d;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic bus_transmit_pin_q;
    logic core_rx_q;
    logic core_clk_en_q;
    logic core_enable_q;
    logic core_tx_allow_q;
    logic core_ack_err_ignore_q;
    logic core_self_receive_q;
    logic wakeup_irq_q;

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = (addr == off);
    endfunction

    // bus decode
    wire setup_ph = psel && !penable;
    wire access_ok = psel && penable && pready_q;
    wire wr_en = access_ok && pwrite && !pslverr_q;
    wire wr_ctrl = wr_en && hit(paddr, CMC_MASTER_CONTROL_OFF);
    wire wr_stat = wr_en && hit(paddr, CMC_MASTER_STATUS_OFF);
    wire wr_diag = wr_en && hit(paddr, CMC_DIAGNOSTIC_CONFIG_OFF);
    wire wr_ien = wr_en && hit(paddr, CMC_IRQ_ENABLE_OFF);
    wire mapped = hit(paddr, CMC_MASTER_CONTROL_OFF)
        || hit(paddr, CMC_MASTER_STATUS_OFF)
        || hit(paddr, CMC_DIAGNOSTIC_CONFIG_OFF)
        || hit(paddr, CMC_IRQ_ENABLE_OFF)
        || hit(paddr, CMC_CAPABILITY_OFF);
    wire diag_open = (state_q == cmc_st_init);

    // mode conditions
    wire in_sleep = (state_q == cmc_st_sleep);
    wire in_normal = (state_q == cmc_st_normal);
    wire wake_evt = in_sleep && !bus_receive_pin;
    wire tx_quiet = !in_normal || silent_select_q;
    // receive path selection; loop-back wins so the pin is cut off in combined mode
    wire silent_rx = bus_receive_pin && core_tx;
    wire rx_mux = loopback_select_q ? core_tx : (silent_select_q ? silent_rx : bus_receive_pin);
    wire idle_bit = core_bit_tick && rx_mux;
    wire sync_done = (state_q == cmc_st_sync) && idle_bit && (idle_cnt_q == CMC_IDLE_LAST);

    // read data
    wire [31:0] ctrl_rd = {29'h0000000, auto_wakeup_select_q, sleep_request_q, init_request_q};
    wire [31:0] stat_rd = {27'h0, rx_mux, pullup_q, wakeup_flag_q,
        sleep_acknowledge_q, init_acknowledge_q};
    wire [31:0] diag_rd = {30'h0, loopback_select_q, silent_select_q};
    wire [31:0] ien_rd = {31'h0, wakeup_irq_enable_q};
    wire [31:0] cap_rd = {8'h00, 8'(CMC_EXT_ID_BITS), 4'(CMC_STD_ID_BITS - 8),
        4'(CMC_RX_FIFO_DEPTH), 4'(CMC_RX_FIFOS), 4'(CMC_TX_MAILBOXES)};
    wire [31:0] rd_mux = hit(paddr, CMC_MASTER_CONTROL_OFF) ? ctrl_rd
        : hit(paddr, CMC_MASTER_STATUS_OFF) ? stat_rd
        : hit(paddr, CMC_DIAGNOSTIC_CONFIG_OFF) ? diag_rd
        : hit(paddr, CMC_IRQ_ENABLE_OFF) ? ien_rd
        : hit(paddr, CMC_CAPABILITY_OFF) ? cap_rd
        : 32'h00000000;

    // mode sequencing
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            cmc_st_sleep:
            begin
                if (!sleep_request_q)
                    state_d = cmc_st_sync;
            end
            cmc_st_init:
            begin
                if (!init_request_q)
                    state_d = sleep_request_q ? cmc_st_sleep : cmc_st_sync;
            end
            cmc_st_sync:
            begin
                if (sleep_request_q)
                    state_d = cmc_st_sleep;
                else if (sync_done)
                    state_d = init_request_q ? cmc_st_init : cmc_st_normal;
                else if (init_request_q && !sleep_acknowledge_q)
                    state_d = cmc_st_init;
            end
            cmc_st_normal:
            begin
                if (init_request_q)
                    state_d = cmc_st_init;
                else if (sleep_request_q)
                    state_d = cmc_st_sleep;
            end
        endcase
    end

    // acknowledges follow the reached mode; sleep acknowledge also stays set through sync after sleep
    assign init_acknowledge_d = (state_d == cmc_st_init);
    assign sleep_acknowledge_d = (state_d == cmc_st_sleep)
        || (sleep_acknowledge_q && state_d == cmc_st_sync);
    assign pullup_d = pullup_q && !((state_d != state_q)
        && (state_d == cmc_st_init || state_d == cmc_st_sleep));
    // hardware wake-up clear wins over a software write in the same cycle
    assign sleep_request_d = (wake_evt && auto_wakeup_select_q) ? 1'b0
        : (wr_ctrl ? pwdata[CMC_SLEEP_REQUEST_BIT] : sleep_request_q);
    // set wins over the write-one clear
    assign wakeup_flag_d = wake_evt
        || (wakeup_flag_q && !(wr_stat && pwdata[CMC_WAKEUP_FLAG_BIT]));
    // recessive run counter, held at zero outside sync
    assign idle_cnt_d = (state_q != cmc_st_sync) ? 4'h0
        : !core_bit_tick ? idle_cnt_q
        : !rx_mux ? 4'h0
        : (idle_cnt_q == CMC_IDLE_LAST) ? 4'h0
        : idle_cnt_q + 4'h1;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_q <= cmc_st_sleep;
            init_acknowledge_q <= 1'b0;
            sleep_acknowledge_q <= CMC_SLEEP_ACK_RST;
            pullup_q <= CMC_PULLUP_RST;
            idle_cnt_q <= 4'h0;
            wakeup_flag_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            init_acknowledge_q <= init_acknowledge_d;
            sleep_acknowledge_q <= sleep_acknowledge_d;
            pullup_q <= pullup_d;
            idle_cnt_q <= idle_cnt_d;
            wakeup_flag_q <= wakeup_flag_d;
        end
    end

    // software registers, reset only by srst and not by mode changes
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            init_request_q <= CMC_INIT_REQUEST_RST;
            sleep_request_q <= CMC_SLEEP_REQUEST_RST;
            auto_wakeup_select_q <= 1'b0;
            silent_select_q <= 1'b0;
            loopback_select_q <= 1'b0;
            wakeup_irq_enable_q <= 1'b0;
        end
        else
        begin
            sleep_request_q <= sleep_request_d;
            if (wr_ctrl)
            begin
                init_request_q <= pwdata[CMC_INIT_REQUEST_BIT];
                auto_wakeup_select_q <= pwdata[CMC_AUTO_WAKEUP_BIT];
            end
            if (wr_diag && diag_open)
            begin
                silent_select_q <= pwdata[CMC_SILENT_BIT];
                loopback_select_q <= pwdata[CMC_LOOPBACK_BIT];
            end
            if (wr_ien)
                wakeup_irq_enable_q <= pwdata[CMC_WAKEUP_IRQ_EN_BIT];
        end
    end

    // apb slave: one access cycle, answer prepared in setup
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            prdata_q <= 32'h00000000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q <= setup_ph;
            pslverr_q <= setup_ph && !mapped;
            if (setup_ph)
                prdata_q <= pwrite ? 32'h00000000 : rd_mux;
        end
    end

    // pin and core side outputs
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            bus_transmit_pin_q <= 1'b1;
            core_rx_q <= 1'b1;
            core_clk_en_q <= 1'b0;
            core_enable_q <= 1'b0;
            core_tx_allow_q <= 1'b0;
            core_ack_err_ignore_q <= 1'b0;
            core_self_receive_q <= 1'b0;
            wakeup_irq_q <= 1'b0;
        end
        else
        begin
            bus_transmit_pin_q <= tx_quiet ? 1'b1 : core_tx;
            core_rx_q <= rx_mux;
            core_clk_en_q <= !in_sleep;
            core_enable_q <= in_normal;
            core_tx_allow_q <= in_normal && !silent_select_q;
            core_ack_err_ignore_q <= loopback_select_q;
            core_self_receive_q <= loopback_select_q;
            wakeup_irq_q <= wakeup_flag_q && wakeup_irq_enable_q;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign bus_transmit_pin = bus_transmit_pin_q;
    assign receive_pullup_pin = pullup_q;
    assign core_rx = core_rx_q;
    assign core_clk_en = core_clk_en_q;
    assign core_enable = core_enable_q;
    assign core_tx_allow = core_tx_allow_q;
    assign core_ack_err_ignore = core_ack_err_ignore_q;
    assign core_self_receive = core_self_receive_q;
    assign wakeup_irq = wakeup_irq_q;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    property p_reset_sleep;
        @(posedge clk) disable iff (1'b0)
        srst |=> (state_q == cmc_st_sleep) && sleep_acknowledge_q && pullup_q;
    endproperty
    a_reset_sleep: assert property (p_reset_sleep)
        else $error("reset did not enter sleep with pull-up");

    property p_init_ack;
        in_normal && init_request_q |=> init_acknowledge_q && !pullup_q;
    endproperty
    a_init_ack: assert property (p_init_ack)
        else $error("init request not acknowledged");

    property p_normal_acks;
        in_normal |-> !init_acknowledge_q && !sleep_acknowledge_q;
    endproperty
    a_normal_acks: assert property (p_normal_acks)
        else $error("normal mode with an acknowledge set");

    property p_sync_idle;
        (state_q == cmc_st_sync) ##1 in_normal |->
            $past(idle_cnt_q) == CMC_IDLE_LAST && $past(idle_bit);
    endproperty
    a_sync_idle: assert property (p_sync_idle)
        else $error("normal entered without eleven recessive bits");

    property p_init_tx;
        (state_q == cmc_st_init) |=> bus_transmit_pin_q && !core_enable_q;
    endproperty
    a_init_tx: assert property (p_init_tx)
        else $error("transmit not recessive in init");

    property p_sleep_no_init;
        in_sleep ##1 in_sleep |-> !init_acknowledge_q;
    endproperty
    a_sleep_no_init: assert property (p_sleep_no_init)
        else $error("init acknowledged while asleep");

    property p_autowake;
        wake_evt && auto_wakeup_select_q |=> !sleep_request_q;
    endproperty
    a_autowake: assert property (p_autowake)
        else $error("auto wake-up did not clear sleep request");

    property p_wake_irq;
        wake_evt && wakeup_irq_enable_q && !wr_ien |=> ##1 wakeup_irq_q;
    endproperty
    a_wake_irq: assert property (p_wake_irq)
        else $error("wake-up interrupt missing");

    property p_sleep_exit;
        $fell(sleep_acknowledge_q) |-> $past(state_q) == cmc_st_sync;
    endproperty
    a_sleep_exit: assert property (p_sleep_exit)
        else $error("sleep acknowledge cleared without sync");

    property p_silent_tx;
        silent_select_q |=> bus_transmit_pin_q && !core_tx_allow_q;
    endproperty
    a_silent_tx: assert property (p_silent_tx)
        else $error("silent mode drove the bus");

    property p_loop_rx;
        loopback_select_q |=> core_rx_q == $past(core_tx);
    endproperty
    a_loop_rx: assert property (p_loop_rx)
        else $error("loop-back receive not fed from transmit");

    property p_sleep_clk;
        in_sleep |=> !core_clk_en_q;
    endproperty
    a_sleep_clk: assert property (p_sleep_clk)
        else $error("core clock enabled in sleep");

    property p_combined;
        silent_select_q && loopback_select_q |=>
            bus_transmit_pin_q && core_rx_q == $past(core_tx);
    endproperty
    a_combined: assert property (p_combined)
        else $error("combined mode not isolated from the bus");

    c_enter_normal: cover property ((state_q == cmc_st_sync) ##1 in_normal);
    c_wake: cover property (wake_evt ##2 wakeup_irq_q);
    c_init: cover property (in_normal ##1 (state_q == cmc_st_init));
    c_combined: cover property (in_normal && silent_select_q && loopback_select_q);

endmodule

// File: verif/cmc_bus_node.sv
`timescale 1ns/1ps
module cmc_bus_node (
    input wire logic clk,
    input wire logic srst,
    input wire logic bus_transmit_pin,
    input wire logic node_dominant,
    output logic bus_receive_pin,
    output logic core_bit_tick
);
    logic [1:0] tick_cnt_q;
    // wired-and bus: recessive unless some node drives dominant
    assign bus_receive_pin = bus_transmit_pin & ~node_dominant;
    // sample point every fourth clock
    always_ff @(posedge clk)
    begin
        if (srst)
            tick_cnt_q <= 2'h0;
        else
            tick_cnt_q <= tick_cnt_q + 2'h1;
    end
    assign core_bit_tick = (tick_cnt_q == 2'h3);
endmodule

// File: verif/cmc_mode_ctrl_tb.sv
`timescale 1ns/1ps
module cmc_mode_ctrl_tb;
    import cmc_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic bus_receive_pin;
    logic bus_transmit_pin;
    logic receive_pullup_pin;
    logic core_tx = 1'b1;
    logic core_bit_tick;
    logic core_rx;
    logic core_clk_en;
    logic core_enable;
    logic core_tx_allow;
    logic core_ack_err_ignore;
    logic core_self_receive;
    logic wakeup_irq;
    logic node_dominant = 1'b0;
    logic [31:0] rd;
    logic err;
    logic [1:0] m;
    int fail_count = 0;
    int cmp_count = 0;
    int n;

    always #5 clk = ~clk;

    cmc_mode_ctrl cmc_mode_ctrl_i (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bus_receive_pin(bus_receive_pin),
        .bus_transmit_pin(bus_transmit_pin), .receive_pullup_pin(receive_pullup_pin),
        .core_tx(core_tx), .core_bit_tick(core_bit_tick), .core_rx(core_rx),
        .core_clk_en(core_clk_en), .core_enable(core_enable), .core_tx_allow(core_tx_allow),
        .core_ack_err_ignore(core_ack_err_ignore), .core_self_receive(core_self_receive),
        .wakeup_irq(wakeup_irq));

    cmc_bus_node cmc_bus_node_i (.clk(clk), .srst(srst), .bus_transmit_pin(bus_transmit_pin),
        .node_dominant(node_dominant), .bus_receive_pin(bus_receive_pin),
        .core_bit_tick(core_bit_tick));

    task automatic report_and_stop();
        if (fail_count == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check32(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check1(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        if (k >= 50)
            fail_count++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h00000000);
        check32(rd, exp);
    endtask

    task automatic wait_stat(input int idx, input logic val);
        int k;
        k = 0;
        do
        begin
            apb(1'b0, CMC_MASTER_STATUS_OFF, 32'h00000000);
            k++;
        end
        while (rd[idx] !== val && k < 100);
        check1(rd[idx], val);
    endtask

    task automatic wait_enable();
        int k;
        k = 0;
        while (core_enable !== 1'b1 && k < 1000)
        begin
            @(posedge clk);
            k++;
        end
        check1(core_enable, 1'b1);
    endtask

    initial
    begin
        #500000;
        fail_count++;
        report_and_stop();
    end

    initial
    begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        check1(receive_pullup_pin, 1'b1);
        check1(core_clk_en, 1'b0);
        rd_chk(CMC_MASTER_STATUS_OFF, 32'h0000001A);
        rd_chk(CMC_MASTER_CONTROL_OFF, 32'h00000002);
        rd_chk(CMC_CAPABILITY_OFF, 32'h001D3323);
        apb(1'b0, 8'h14, 32'h00000000);
        check1(err, 1'b1);
        check32(rd, 32'h00000000);
        apb(1'b1, CMC_MASTER_CONTROL_OFF, 32'h00000003);
        repeat (100) @(posedge clk);
        rd_chk(CMC_MASTER_STATUS_OFF, 32'h0000001A);
        apb(1'b1, CMC_MASTER_CONTROL_OFF, 32'h00000001);
        wait_stat(CMC_INIT_ACK_BIT, 1'b1);
        rd_chk(CMC_MASTER_STATUS_OFF, 32'h00000011);
        check1(receive_pullup_pin, 1'b0);
        check1(bus_transmit_pin, 1'b1);
        check1(core_enable, 1'b0);
        apb(1'b1, CMC_IRQ_ENABLE_OFF, 32'h00000001);
        for (int v = 0; v < 4; v++)
        begin
            m = 2'(v);
            apb(1'b1, CMC_DIAGNOSTIC_CONFIG_OFF, 32'(m));
            rd_chk(CMC_IRQ_ENABLE_OFF, 32'h00000001);
            node_dominant <= 1'b1;
            apb(1'b1, CMC_MASTER_CONTROL_OFF, 32'h00000000);
            wait_stat(CMC_INIT_ACK_BIT, 1'b0);
            if (!m[1])
            begin
                repeat (60) @(posedge clk);
                check1(core_enable, 1'b0);
                do @(posedge clk); while (core_bit_tick !== 1'b1);
                node_dominant <= 1'b0;
                n = 0;
                while (core_enable !== 1'b1 && n < 20)
                begin
                    @(posedge clk);
                    if (core_bit_tick === 1'b1)
                        n++;
                end
                check32(32'(n), 32'(CMC_IDLE_BITS));
            end
            node_dominant <= 1'b0;
            wait_enable();
            check1(core_clk_en, 1'b1);
            check1(core_tx_allow, ~m[0]);
            check1(core_ack_err_ignore, m[1]);
            check1(core_self_receive, m[1]);
            core_tx <= 1'b0;
            repeat (3) @(posedge clk);
            check1(bus_transmit_pin, m[0]);
            check1(core_rx, 1'b0);
            core_tx <= 1'b1;
            node_dominant <= 1'b1;
            repeat (3) @(posedge clk);
            check1(core_rx, m[1]);
            node_dominant <= 1'b0;
            repeat (3) @(posedge clk);
            rd_chk(CMC_MASTER_STATUS_OFF, 32'h00000010);
            apb(1'b1, CMC_DIAGNOSTIC_CONFIG_OFF, 32'h00000000);
            rd_chk(CMC_DIAGNOSTIC_CONFIG_OFF, 32'(m));
            apb(1'b1, CMC_MASTER_CONTROL_OFF, 32'h00000001);
            wait_stat(CMC_INIT_ACK_BIT, 1'b1);
        end
        apb(1'b1, CMC_DIAGNOSTIC_CONFIG_OFF, 32'h00000000);
        apb(1'b1, CMC_MASTER_CONTROL_OFF, 32'h00000000);
        wait_enable();
        apb(1'b1, CMC_MASTER_CONTROL_OFF, 32'h00000006);
        wait_stat(CMC_SLEEP_ACK_BIT, 1'b1);
        check1(core_clk_en, 1'b0);
        node_dominant <= 1'b1;
        repeat (4) @(posedge clk);
        check1(wakeup_irq, 1'b1);
        rd_chk(CMC_MASTER_CONTROL_OFF, 32'h00000004);
        rd_chk(CMC_MASTER_STATUS_OFF, 32'h00000006);
        node_dominant <= 1'b0;
        wait_enable();
        rd_chk(CMC_MASTER_STATUS_OFF, 32'h00000014);
        apb(1'b1, CMC_MASTER_STATUS_OFF, 32'h00000004);
        repeat (3) @(posedge clk);
        check1(wakeup_irq, 1'b0);
        apb(1'b1, CMC_MASTER_CONTROL_OFF, 32'h00000002);
        wait_stat(CMC_SLEEP_ACK_BIT, 1'b1);
        node_dominant <= 1'b1;
        repeat (2) @(posedge clk);
        node_dominant <= 1'b0;
        repeat (20) @(posedge clk);
        rd_chk(CMC_MASTER_CONTROL_OFF, 32'h00000002);
        check1(wakeup_irq, 1'b1);
        rd_chk(CMC_MASTER_STATUS_OFF, 32'h00000016);
        apb(1'b1, CMC_MASTER_CONTROL_OFF, 32'h00000000);
        wait_enable();
        wait_stat(CMC_SLEEP_ACK_BIT, 1'b0);
        report_and_stop();
    end
endmodule
